// ### verilog/hufc_uart.v
// Purpose: NRZ serial port for host-interface packets, RTS/CTS flow, pins shared with GPIO
// Assumes: All inputs synchronous to sys_clk; pin_* are the four shared pad signals
// Notes: Pin 0 data out, pin 1 data in, pin 2 RTS out, pin 3 CTS in; flow signals active low
`timescale 1ns/1ps
`default_nettype none
`include "hufc_map.vh"

module hufc_uart #(
  parameter CLK_HZ = `HUFC_CLK_HZ,
  parameter BAUD = `HUFC_BAUD,
  parameter DATA_BITS = `HUFC_DATA_BITS
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [3:0] pin_function_select,
  input wire parity_en,
  input wire parity_odd,
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_oe,
  output wire [3:0] gpio_in,
  input wire [3:0] pin_in,
  output wire [3:0] pin_out,
  output wire [3:0] pin_oe,
  input wire [DATA_BITS-1:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output reg [DATA_BITS-1:0] rx_data,
  output reg rx_valid,
  input wire rx_ack,
  output reg rx_frame_err,
  output reg rx_parity_err,
  output reg rx_overrun,
  input wire err_clear,
  output wire uart_active
);

  localparam integer BIT_CYC = CLK_HZ / BAUD;
  localparam integer HALF_CYC = BIT_CYC / 2;
  localparam integer CW = 16;
  // Bit period truncates; keep CLK_HZ close to a multiple of BAUD
  localparam integer BIT_LAST_I = BIT_CYC - 1;
  localparam integer HALF_LAST_I = HALF_CYC - 1;
  localparam integer NBITS_I = DATA_BITS;
  localparam [CW-1:0] BIT_LAST = BIT_LAST_I[CW-1:0];
  localparam [CW-1:0] HALF_LAST = HALF_LAST_I[CW-1:0];
  localparam [3:0] NBITS = NBITS_I[3:0];

  // Frame states, shared by both directions
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_PAR = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;

  // ----------------------------------------
  // Pin sharing
  // ----------------------------------------
  // pins claimed by config
  assign uart_active = (pin_function_select == `HUFC_SEL_UART);

  // Both pad outputs are registers so the pads never see decode glitches
  reg tx_line_q;
  reg rts_n_q;
  wire rxd = uart_active ? pin_in[`HUFC_PIN_RXD] : 1'b1;
  // CTS is only read between frames; a frame in flight always finishes
  // crossed partner RTS as CTS
  wire cts_ok = uart_active & ~pin_in[`HUFC_PIN_CTS];

  // Port-mode levels per pad; input pads read back as 0
  wire [3:0] uart_out = {1'b0, rts_n_q, 1'b0, tx_line_q};

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // null-modem pin roles
  function pin_drives;
    input integer idx;
    begin
      pin_drives = (idx == `HUFC_PIN_TXD) || (idx == `HUFC_PIN_RTS);
    end
  endfunction

  function [CW-1:0] cnt_next;
    input [CW-1:0] cnt;
    input restart;
    begin
      cnt_next = restart ? {CW{1'b0}} : cnt + 1'b1;
    end
  endfunction

  function parity_of;
    input [DATA_BITS-1:0] d;
    input odd;
    begin
      parity_of = (^d) ^ odd;
    end
  endfunction

  // One lane per shared pad; port mode drives only the two outputs
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      assign pin_out[gi] = uart_active ? uart_out[gi] : gpio_out[gi];
      assign pin_oe[gi] = uart_active ? pin_drives(gi) : gpio_oe[gi];
      assign gpio_in[gi] = uart_active ? 1'b0 : pin_in[gi];
    end
  endgenerate

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [2:0] tx_st_q;
  reg [CW-1:0] tx_cnt_q;
  reg [3:0] tx_idx_q;
  reg [DATA_BITS-1:0] tx_sh_q;
  reg tx_par_q;
  wire tx_tick = (tx_cnt_q == BIT_LAST);

  // Combinational so the next byte can follow the stop bit directly
  // start only with CTS
  assign tx_ready = (tx_st_q == ST_IDLE) & cts_ok;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tx_st_q <= ST_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_idx_q <= 4'h0;
      tx_sh_q <= {DATA_BITS{1'b0}};
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else
    begin
      tx_cnt_q <= cnt_next(tx_cnt_q, tx_st_q == ST_IDLE || tx_tick);
      case (tx_st_q)
        ST_IDLE:
        begin
          tx_line_q <= 1'b1;
          if (tx_valid && tx_ready)
          begin
            tx_line_q <= 1'b0;
            tx_sh_q <= tx_data;
            tx_par_q <= parity_of(tx_data, parity_odd);
            tx_idx_q <= 4'h0;
            tx_st_q <= ST_START;
          end
        end
        ST_START:
          if (tx_tick)
          begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q <= tx_sh_q >> 1;
            tx_st_q <= ST_DATA;
          end
        ST_DATA:
          if (tx_tick)
          begin
            if (tx_idx_q == NBITS - 4'h1)
            begin
              tx_line_q <= parity_en ? tx_par_q : 1'b1;
              tx_st_q <= parity_en ? ST_PAR : ST_STOP;
            end
            else
            begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q <= tx_sh_q >> 1;
              tx_idx_q <= tx_idx_q + 4'h1;
            end
          end
        ST_PAR:
          if (tx_tick)
          begin
            tx_line_q <= 1'b1;
            tx_st_q <= ST_STOP;
          end
        ST_STOP:
          if (tx_tick)
            tx_st_q <= ST_IDLE;
        default:
          tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg [2:0] rx_st_q;
  reg [CW-1:0] rx_cnt_q;
  reg [3:0] rx_idx_q;
  reg [DATA_BITS-1:0] rx_sh_q;
  reg rx_par_q;
  wire rx_tick = (rx_cnt_q == BIT_LAST);

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_st_q <= ST_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_idx_q <= 4'h0;
      rx_sh_q <= {DATA_BITS{1'b0}};
      rx_par_q <= 1'b0;
      rx_data <= {DATA_BITS{1'b0}};
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_overrun <= 1'b0;
    end
    else
    begin
      // Host read frees the holding register
      if (rx_ack)
        rx_valid <= 1'b0;
      // Error flags: hardware set beats software clear
      if (err_clear)
      begin
        rx_frame_err <= 1'b0;
        rx_parity_err <= 1'b0;
        rx_overrun <= 1'b0;
      end
      rx_cnt_q <= cnt_next(rx_cnt_q, rx_st_q == ST_IDLE || rx_tick);
      case (rx_st_q)
        ST_IDLE:
          if (!rxd)
            rx_st_q <= ST_START;
        ST_START:
          if (rx_cnt_q == HALF_LAST)
          begin
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 4'h0;
            rx_par_q <= parity_odd;
            // Glitch shorter than half a bit is ignored
            rx_st_q <= rxd ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (rx_tick)
          begin
            rx_sh_q <= {rxd, rx_sh_q[DATA_BITS-1:1]};
            rx_par_q <= rx_par_q ^ rxd;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == NBITS - 4'h1)
              rx_st_q <= parity_en ? ST_PAR : ST_STOP;
          end
        ST_PAR:
          if (rx_tick)
          begin
            if (rx_par_q ^ rxd)
              rx_parity_err <= 1'b1;
            rx_st_q <= ST_STOP;
          end
        ST_STOP:
          if (rx_tick)
          begin
            if (!rxd)
              rx_frame_err <= 1'b1;
            // Only a partner that ignores RTS can get here
            // overrun keeps old byte
            if (rx_valid && !rx_ack)
              rx_overrun <= 1'b1;
            else
            begin
              rx_data <= rx_sh_q;
              rx_valid <= 1'b1;
            end
            // Stop sampled mid-bit; back to idle leaves half a bit for next edge
            rx_st_q <= ST_IDLE;
          end
        default:
          rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Flow control
  // ----------------------------------------
  // RTS only when free
  // Lags a start edge by one cycle; the partner is mid-character then anyway
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      rts_n_q <= 1'b1;
    else
      rts_n_q <= ~((rx_st_q == ST_IDLE) & ~rx_valid);
  end

endmodule // hufc_uart
`default_nettype wire

// ### verilog/hufc_map.vh
// Purpose: Constants for the host-link serial port with RTS/CTS flow control
// Assumes: Included by hufc_uart.v only
// Notes: Timing counts are in sys_clk cycles at 100 MHz
//
// Notes on behaviour
// - The port has only one line format, NRZ, and nothing selects another.
// - Each character is one frame opened by one start bit and closed by a stop bit.
// - Data goes least significant bit first and every bit lasts exactly one bit period.
// - When parity is on, its bit sits right after the top data bit and before the stop bit.
// - The port carries host-interface packets between the chip and an outside host.
// - Host transport uses 8 data bits, no parity, one stop bit and RTS/CTS flow control.
// - The link is crossed null-modem: data out to the far receive pin, RTS to far CTS.
// - There are no DTR or DSR signals; only data and the RTS/CTS pair are used.
// - The device holds RTS active only while it can take another received character.
// - The device starts a new character only while its CTS input is active.
// - The port shares four general-purpose pins and takes them only once software configures it.
// - The pins carry the port when the 4-bit pin function select equals all ones.
`ifndef HUFC_MAP_VH
`define HUFC_MAP_VH

`define HUFC_CLK_HZ 100000000
`define HUFC_BAUD 115200
`define HUFC_DATA_BITS 8
`define HUFC_SEL_UART 4'hf
`define HUFC_PIN_TXD 0
`define HUFC_PIN_RXD 1
`define HUFC_PIN_RTS 2
`define HUFC_PIN_CTS 3

`endif

// ### verif/hufc_chk_checker.sv
// Purpose: Port checks for the host-link serial port
// Assumes: One clock, sync reset
// Notes: Bit period is CLK_HZ/BAUD cycles
`timescale 1ns/1ps
`default_nettype none
module hufc_chk #(parameter CLK_HZ = 16, parameter BAUD = 1) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] pin_function_select,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic uart_active
);
  // ----
  // Assertions
  // ----
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_start;
    !pin_out[0] [*8];
  endsequence
  a_sel_decode: assert property (uart_active == (pin_function_select == 4'hf)) else $error("mode");
  a_gpio_pass: assert property (!uart_active |-> pin_out == gpio_out && pin_oe == gpio_oe) else $error("gpio");
  a_uart_oe: assert property (uart_active |-> pin_oe == 4'h5) else $error("oe");
  a_cts_gate: assert property (tx_ready |-> uart_active && !pin_in[3]) else $error("cts");
  a_start_low: assert property (s_take |=> s_start) else $error("start");
  a_busy_hold: assert property (s_take |=> !tx_ready [*8]) else $error("busy");
  a_idle_high: assert property (tx_ready |-> pin_out[0]) else $error("idle");
  a_rts_off: assert property (uart_active && rx_valid |-> pin_out[2]) else $error("rts");
endmodule // hufc_chk
bind hufc_uart hufc_chk #(.CLK_HZ(CLK_HZ), .BAUD(BAUD)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .pin_function_select(pin_function_select), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .uart_active(uart_active));
`default_nettype wire

// ### verif/hufc_host.sv
// Purpose: Far-end host model, 8N1 with RTS/CTS
// Assumes: Active-low flow lines
// Notes: Bits driven and sampled at falling clock edge
`timescale 1ns/1ps
`default_nettype none
module hufc_host #(parameter int BC = 16) (
  input wire logic clk,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic hold,
  output logic rxd,
  output logic cts_n
);
  // ----
  // Link model
  // ----
  logic [8:0] got_q[$];
  logic [8:0] f;
  assign cts_n = hold;
  // wait up to 2000 cycles for RTS, then send anyway, LSB first
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] fr;
    int n;
    fr = {stp, b, 1'b0};
    for (n = 0; n < 2000 && rts_n !== 1'b0; n++) @(negedge clk);
    for (int i = 0; i < 10; i++)
    begin
      rxd = fr[i];
      repeat (BC) @(negedge clk);
    end
    rxd = 1'b1;
  endtask
  // sample mid-bit, stop or parity kept in bit 8
  initial
  begin
    rxd = 1'b1;
    forever
    begin
      @(negedge txd);
      repeat (BC / 2) @(negedge clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BC) @(negedge clk);
        f[i] = txd;
      end
      got_q.push_back(f);
    end
  end
endmodule // hufc_host
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench for hufc_uart
// Assumes: Bit period shortened to 16 cycles
// Notes: Inputs change on falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----
  // Bench
  // ----
  localparam int BC = 16;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] pfs, g_out, g_oe, pad;
  logic [7:0] tx_data;
  logic tx_valid, rx_ack, err_clear, hold, par_en, par_odd;
  logic [31:0] seed = 34;
  logic [31:0] r;
  logic [8:0] exp_q[$];
  int err_count = 0;
  int checks = 0;
  int n;
  wire logic [3:0] gpio_in, pin_out, pin_oe;
  wire logic [7:0] rx_data;
  wire logic tx_ready, rx_valid, rx_frame_err, rx_parity_err, rx_overrun, uart_active, rxd, cts_n;
  wire logic [3:0] pin_in = {cts_n, pad[2], rxd, pad[0]};
  always #5 sys_clk = ~sys_clk;
  hufc_uart #(.CLK_HZ(BC), .BAUD(1)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_function_select(pfs),
    .parity_en(par_en), .parity_odd(par_odd), .gpio_out(g_out), .gpio_oe(g_oe), .gpio_in(gpio_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ack(rx_ack), .rx_frame_err(rx_frame_err),
    .rx_parity_err(rx_parity_err), .rx_overrun(rx_overrun), .err_clear(err_clear), .uart_active(uart_active));
  hufc_host #(.BC(BC)) u_host (.clk(sys_clk), .txd(uart_active ? pin_out[0] : 1'b1), .rts_n(pin_out[2]),
    .hold(hold), .rxd(rxd), .cts_n(cts_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic test_done();
    $display("Checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask
  // Bounded waits end the run when exhausted
  task automatic tmo();
    if (n >= 2000)
    begin
      err_count++;
      test_done();
    end
  endtask
  task automatic put(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    for (n = 0; n < 2000 && tx_ready !== 1'b1; n++) @(negedge sys_clk);
    tmo();
    exp_q.push_back({par_en ? (^b ^ par_odd) : 1'b1, b});
    @(negedge sys_clk);
  endtask
  initial
  begin
    {pfs, g_out, g_oe, pad, tx_data, tx_valid, rx_ack, err_clear, hold, par_en, par_odd} = '0;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      pfs = (r[3:0] == 4'hf) ? 4'h0 : r[3:0];
      {pad, g_oe, g_out} = r[15:4];
      @(negedge sys_clk);
      chk({4'h0, pin_out, pin_oe, gpio_in}, {4'h0, g_out, g_oe, pin_in});
    end
    pfs = 4'hf;
    hold = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk({pin_oe, gpio_in, 7'h0, tx_ready}, 16'h5000);
    hold = 1'b0;
    @(negedge sys_clk);
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      put(r[7:0]);
    end
    tx_valid = 1'b0;
    for (n = 0; n < 2000 && u_host.got_q.size() < 3; n++) @(negedge sys_clk);
    tmo();
    for (int i = 0; i < 3; i++)
      chk({7'h0, u_host.got_q[i]}, {7'h0, exp_q[i]});
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      u_host.send(r[7:0], i != 3);
      for (n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge sys_clk);
      tmo();
      chk({6'h0, rx_frame_err, rx_valid, rx_data}, {6'h0, i == 3, 1'b1, r[7:0]});
      rx_ack = 1'b1;
      err_clear = 1'b1;
      @(negedge sys_clk);
      rx_ack = 1'b0;
      err_clear = 1'b0;
    end
    r = rnd();
    par_en = 1'b1;
    par_odd = r[9];
    put(r[7:0]);
    tx_valid = 1'b0;
    for (n = 0; n < 2000 && u_host.got_q.size() < 4; n++) @(negedge sys_clk);
    tmo();
    chk({7'h0, u_host.got_q[3]}, {7'h0, exp_q[3]});
    u_host.send(r[7:0], ^r[7:0] ^ par_odd ^ r[8]);
    for (n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge sys_clk);
    tmo();
    chk({6'h0, rx_parity_err, rx_valid, rx_data}, {6'h0, r[8], 1'b1, r[7:0]});
    rx_ack = 1'b1;
    err_clear = 1'b1;
    @(negedge sys_clk);
    rx_ack = 1'b0;
    err_clear = 1'b0;
    par_en = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({11'h0, rx_parity_err, rx_overrun, rx_frame_err, rx_valid, pin_out[2]}, 16'h0000);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
